// file: design/rtcp_core.sv
// rtcp_core: time/calendar chain, RAM, alarm, watchdog, clock output and power
// control behind an APB slave; pins from outside arrive unsynchronised.
`default_nettype none
// Contract
// - Sense input level at reset end picks single-supply or battery-backup mode.
// - Single-supply: enable clock, supply-enable and cpu reset after reset.
// - Single-supply: pull cpu reset low while sense input is low.
// - Battery: hold outputs low until sense input rises above cell threshold.
// - Battery: disable outputs again whenever sense input drops below threshold.
// - Advance time chain once per one-hertz tick from prescaler or line.
// - Keep 12 or 24 hour format; AM/PM toggles every twelve hours.
// - Counters held in BCD at indices 20h..26h; hours carry format flags.
// - Indices 00h..1Fh reach the 32-byte RAM by low five bits.
// - Alarm event when alarm seconds, minutes, hours equal the time.
// - Alarm pulls interrupt low only when enabled; always sets alarm flag.
// - Missed watchdog service gives a cpu reset pulse and watchdog flag.
// - Service within one time-base tick; reset after three to four ticks.
// - Clock output picks one of seven rates; forced low in power-down.
// - Clock and interrupt control read-write; status register read-only.
// - Power sense raises interrupt and flag after line goes quiet 2.68ms.
// - Power-down drops supply-enable, clock output, cpu reset; bus disabled.
// - Any interrupt ends power-down.
// - Sense input falling then rising ends power-down in either mode.
// - Interrupt control bit 6 is the power-down bit.
// - Interrupt output released only by a status register read.
module rtcp_core
  import rtcp_pkg::*;
#(
  parameter int SUB_CYCLES = SUB_CYCLES_DEF,
  parameter int SENSE_CYCLES = SENSE_CYCLES_DEF
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins from outside
  input wire logic chipEnable,
  input wire logic lineIn,
  input wire logic systemLevelIn,
  // power control outputs
  output logic supplyEnableOut,
  output logic clkOut,
  // open-drain cpu reset and interrupt
  input wire logic cpuResetIn,
  output logic cpuResetOutN,
  output logic cpuResetOe,
  input wire logic intIn,
  output logic intOutN,
  output logic intOe
);

  // counters are 20 bits wide
  if (SUB_CYCLES < 2 || SUB_CYCLES > 1_048_575 || SENSE_CYCLES < 2 ||
      SENSE_CYCLES > 1_048_575)
  begin : g_check
    $error("rtcp_core: count parameter out of range");
  end

  localparam logic [19:0] SUB_LAST = 20'(SUB_CYCLES - 1);
  localparam logic [19:0] SENSE_LAST = 20'(SENSE_CYCLES - 1);

  rtcp_state_type st, n;
  logic setup, access, mapped, wrEn, statusRd, ceEdge, lineRise, lineEdge;
  logic subTick, lineSec, tick1s, dayCarry, almMatch, alarmEv, perEv, senseOn;
  logic senseEv, wdTick, wdFire, intEv, outEn;
  logic [5:0] idx;
  logic [7:0] rdVal, stSet;
  logic [8:0] c9;

  // one bcd digit pair step: wraps top to low and reports the carry
  function automatic logic [8:0] bcdStep(input logic [7:0] v, input logic [7:0] top,
                                          input logic [7:0] low);
    if (v == top)
      return {1'b1, low};
    if (v[3:0] == 4'h9)
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    return {1'b0, v[7:4], v[3:0] + 4'h1};
  endfunction

  // last date of a month, leap years every fourth bcd year
  function automatic logic [7:0] monthEnd(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
                   (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    if (mon == 8'h02)
      return leap ? 8'h29 : 8'h28;
    if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11)
      return 8'h30;
    return 8'h31;
  endfunction

  // apb decode; the slave never waits
  assign idx = paddr[7:2];
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign pready = 1'b1;
  assign mapped = (idx <= IDX_YEAR) || (idx inside {[IDX_ALM_SEC:IDX_ALM_HR]}) ||
                  (idx inside {[IDX_STATUS:IDX_INTCTL]});
  assign pslverr = access & (~mapped | st.icr[ICR_PDOWN]);
  assign wrEn = access & pwrite & ~pslverr & pstrb[0];
  assign statusRd = access & ~pwrite & ~pslverr & (idx == IDX_STATUS);

  // registered outputs; open-drain pins drive low only when enabled
  assign prdata = {24'h00_0000, st.rdata};
  assign supplyEnableOut = st.supply_enable_out;
  assign clkOut = st.clkOut;
  assign cpuResetOutN = st.cpuRstN;
  assign cpuResetOe = ~st.cpuRstN;
  assign intOutN = ~st.intLow;
  assign intOe = st.intLow;

  // next-state logic for the whole block
  always_comb
  begin
    n = st;
    c9 = 9'h000;
    dayCarry = 1'b0;
    lineSec = 1'b0;
    wdFire = 1'b0;
    senseEv = 1'b0;
    rdVal = 8'h00;
    stSet = 8'h00;

    // three-stage synchronisers; a change counts once stages two and three agree
    n.s1 = {systemLevelIn, lineIn, chipEnable};
    n.s2 = st.s1;
    n.s3 = st.s2;
    n.filt = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.filt);
    ceEdge = n.filt[0] ^ st.filt[0];
    lineEdge = n.filt[1] ^ st.filt[1];
    lineRise = n.filt[1] & ~st.filt[1];

    // mode caught once the sense input has settled after reset
    if (st.mode == MODE_START)
    begin
      n.startCnt = st.startCnt + 3'h1;
      if (st.startCnt == START_WAIT)
        n.mode = st.filt[2] ? MODE_SINGLE : MODE_BATTERY;
    end

    // crystal prescaler: free 128 Hz stage, stoppable divide to one hertz
    n.fast = st.fast + 4'h1;
    subTick = (st.subCnt == SUB_LAST);
    n.subCnt = subTick ? 20'h0_0000 : st.subCnt + 20'h0_0001;
    if (!st.ccr[CCR_START])
      n.hz128 = 7'h00;
    else if (subTick)
      n.hz128 = st.hz128 + 7'h01;

    // line time base counts 50 or 60 rising edges a second
    if (!st.ccr[CCR_START])
      n.lineCnt = 6'h00;
    else if (lineRise)
    begin
      if (st.lineCnt == (st.ccr[CCR_50HZ] ? LINE_50 : LINE_60) - 6'h01)
      begin
        n.lineCnt = 6'h00;
        lineSec = 1'b1;
      end
      else
        n.lineCnt = st.lineCnt + 6'h01;
    end
    // one-hertz tick from the selected source
    tick1s = st.ccr[CCR_LINE] ? lineSec :
             (st.ccr[CCR_START] & subTick & (st.hz128 == 7'h7F));

    if (tick1s)
    begin
      c9 = bcdStep(st.tm[0], 8'h59, 8'h00);
      n.tm[0] = c9[7:0];
      if (c9[8])
      begin
        c9 = bcdStep(st.tm[1], 8'h59, 8'h00);
        n.tm[1] = c9[7:0];
        if (c9[8])
        begin
          // 12-hour: AM/PM flips at eleven to twelve
          if (st.tm[2][HR_12])
          begin
            if (st.tm[2][4:0] == 5'h12)
              n.tm[2][4:0] = 5'h01;
            else if (st.tm[2][4:0] == 5'h11)
            begin
              n.tm[2][4:0] = 5'h12;
              n.tm[2][HR_PM] = ~st.tm[2][HR_PM];
              dayCarry = st.tm[2][HR_PM];
            end
            else
            begin
              c9 = bcdStep({3'h0, st.tm[2][4:0]}, 8'h12, 8'h01);
              n.tm[2][4:0] = c9[4:0];
            end
          end
          else
          begin
            c9 = bcdStep(st.tm[2], 8'h23, 8'h00);
            n.tm[2] = c9[7:0];
            dayCarry = c9[8];
          end
        end
      end
    end
    // calendar: day of week, date, month, year with leap february
    if (dayCarry)
    begin
      c9 = bcdStep(st.tm[3], 8'h07, 8'h01);
      n.tm[3] = c9[7:0];
      c9 = bcdStep(st.tm[4], monthEnd(st.tm[5], st.tm[6]), 8'h01);
      n.tm[4] = c9[7:0];
      if (c9[8])
      begin
        c9 = bcdStep(st.tm[5], 8'h12, 8'h01);
        n.tm[5] = c9[7:0];
        if (c9[8])
        begin
          c9 = bcdStep(st.tm[6], 8'h99, 8'h00);
          n.tm[6] = c9[7:0];
        end
      end
    end

    // compare on the cycle after each seconds update, once only
    n.cmpPend = tick1s;
    // hours compared with format bit and unused bit masked
    almMatch = (st.tm[0] == st.alm[0]) && (st.tm[1] == st.alm[1]) &&
               (st.tm[2][5:0] == st.alm[2][5:0]);
    alarmEv = st.cmpPend & almMatch;
    // any nonzero periodic select gives one event per second
    perEv = tick1s & (st.icr[3:0] != 4'h0);

    // power sense: line must stay quiet for the full delay
    senseOn = st.icr[ICR_PSENSE] & ~st.ccr[CCR_LINE];
    if (lineEdge || !senseOn)
    begin
      n.senseCnt = 20'h0_0000;
      n.senseDone = 1'b0;
    end
    else if (!st.senseDone)
    begin
      n.senseCnt = st.senseCnt + 20'h0_0001;
      if (st.senseCnt == SENSE_LAST)
      begin
        senseEv = 1'b1;
        n.senseDone = 1'b1;
      end
    end

    // watchdog ticks on line edges or the 128 Hz crystal stage
    wdTick = st.ccr[CCR_LINE] ? lineEdge : subTick;
    if (ceEdge)
      n.ceSeen = 1'b1;
    // one tick to serve, third silent tick fires
    if (!st.icr[ICR_WDOG])
    begin
      n.wdCnt = 2'h0;
      n.ceSeen = 1'b0;
    end
    else if (wdTick)
    begin
      if (st.ceSeen || ceEdge)
      begin
        n.wdCnt = 2'h0;
        n.ceSeen = 1'b0;
      end
      else if (st.wdCnt == WD_LAST)
      begin
        n.wdCnt = 2'h0;
        wdFire = ~st.wdLock;
      end
      else
        n.wdCnt = st.wdCnt + 2'h1;
    end
    // reset pulse lasts one watchdog tick period
    if (wdTick)
      n.wdPulse = 1'b0;
    if (statusRd)
      n.wdLock = 1'b0;
    if (wdFire)
    begin
      n.wdPulse = 1'b1;
      n.wdLock = 1'b1;
    end

    // register read mux, captured in the setup phase
    if (idx <= IDX_RAM_LAST)
      rdVal = st.ram[idx[4:0]];
    else if (idx <= IDX_YEAR)
      rdVal = st.tm[idx[2:0]];
    else if (idx inside {[IDX_ALM_SEC:IDX_ALM_HR]})
      rdVal = st.alm[idx[1:0]];
    else if (idx == IDX_STATUS)
      rdVal = st.status;
    else if (idx == IDX_CLKCTL)
      rdVal = st.ccr;
    else if (idx == IDX_INTCTL)
      rdVal = st.icr;
    if (setup)
      n.rdata = rdVal;

    // writes; status ignores writes, host writes beat the counter step
    if (wrEn)
    begin
      if (idx <= IDX_RAM_LAST)
        n.ram[idx[4:0]] = pwdata[7:0];
      else if (idx <= IDX_YEAR)
        n.tm[idx[2:0]] = pwdata[7:0];
      else if (idx inside {[IDX_ALM_SEC:IDX_ALM_HR]})
        n.alm[idx[1:0]] = pwdata[7:0];
      else if (idx == IDX_CLKCTL)
        n.ccr = pwdata[7:0];
      else if (idx == IDX_INTCTL)
        n.icr = pwdata[7:0];
    end

    // alarm flag always set, interrupt only when enabled
    stSet[ST_ALARM] = alarmEv;
    stSet[ST_PERIOD] = perEv;
    stSet[ST_PSENSE] = senseEv;
    stSet[ST_WDOG] = wdFire;
    intEv = (alarmEv & st.icr[ICR_ALARM]) | perEv | senseEv;
    // only bits the host actually saw are cleared; a new event wins
    n.status = (st.status & ~(statusRd ? st.rdata : 8'h00)) | stSet;
    // interrupt held until a status read leaves nothing pending
    n.intLow = intEv |
               (st.intLow & (~statusRd | (|(st.status[2:0] & ~st.rdata[2:0]))));

    if (intEv)
      n.icr[ICR_PDOWN] = 1'b0;
    // sense input low then high ends power-down
    if (!st.icr[ICR_PDOWN])
      n.sawLow = 1'b0;
    else if (!st.filt[2])
      n.sawLow = 1'b1;
    else if (st.sawLow)
    begin
      n.icr[ICR_PDOWN] = 1'b0;
      n.sawLow = 1'b0;
    end

    // outputs enabled by mode, sense level and power-down
    outEn = (st.mode != MODE_START) && !st.icr[ICR_PDOWN] &&
            (st.mode == MODE_SINGLE || st.filt[2]);
    n.supply_enable_out = outEn;
    // cpu reset follows a low sense input and the watchdog pulse
    n.cpuRstN = outEn & st.filt[2] & ~st.wdPulse;
    // clock output rate select, low when disabled
    unique case (st.ccr[2:0])
      CKO_OFF: n.clkOut = 1'b0;
      CKO_1HZ: n.clkOut = outEn & st.hz128[6];
      CKO_2HZ: n.clkOut = outEn & st.hz128[5];
      CKO_LINE: n.clkOut = outEn & (st.ccr[CCR_LINE] ? st.filt[1] : st.hz128[0]);
      default: n.clkOut = outEn & st.fast[st.ccr[1:0]];
    endcase
  end

  // state register; mode and pins settle after release
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st <= '0;
      st.ccr <= CCR_RST;
      st.icr <= ICR_RST;
      st.status <= STATUS_RST;
      st.tm[3] <= CAL_RST;
      st.tm[4] <= CAL_RST;
      st.tm[5] <= CAL_RST;
      st.mode <= MODE_START;
    end
    else
      st <= n;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_alarm_hit;
    st.cmpPend && almMatch;
  endsequence

  sequence s_quiet_end;
    senseOn && !lineEdge && !st.senseDone && (st.senseCnt == SENSE_LAST);
  endsequence

  sequence s_clkctl_write;
    wrEn && (idx == IDX_CLKCTL);
  endsequence

  a_alarm_flag: assert property (s_alarm_hit |=> st.status[ST_ALARM])
    else $error("alarm match did not set the alarm flag");
  a_alarm_int_on: assert property (
    s_alarm_hit ##0 st.icr[ICR_ALARM] |=> intOe && !intOutN)
    else $error("enabled alarm did not pull the interrupt low");
  a_alarm_int_off: assert property (
    s_alarm_hit ##0 (!st.icr[ICR_ALARM] && !st.intLow && !perEv && !senseEv) |=> !intOe)
    else $error("masked alarm pulled the interrupt low");
  a_int_hold: assert property (st.intLow && !statusRd |=> st.intLow)
    else $error("interrupt released without a status read");
  a_pdown_outs: assert property (
    st.icr[ICR_PDOWN] |=> !supplyEnableOut && !clkOut && !cpuResetOutN)
    else $error("power-down left an output high");
  a_pdown_wake: assert property (intEv && st.icr[ICR_PDOWN] |=> !st.icr[ICR_PDOWN])
    else $error("interrupt did not end power-down");
  a_single_rst: assert property (
    st.mode == MODE_SINGLE && !st.filt[2] |=> !cpuResetOutN)
    else $error("low sense input did not hold cpu reset low");
  a_batt_off: assert property (
    st.mode == MODE_BATTERY && !st.filt[2] |=> !supplyEnableOut && !clkOut)
    else $error("battery mode outputs on below threshold");
  a_wd_fire: assert property (
    wdFire |=> st.status[ST_WDOG] && st.wdPulse ##1 !cpuResetOutN)
    else $error("watchdog timeout gave no reset pulse");
  a_sense_delay: assert property (s_quiet_end |=> st.status[ST_PSENSE] && intOe)
    else $error("power sense did not flag after the quiet delay");
  a_clk_off: assert property (st.ccr[2:0] == CKO_OFF |=> !clkOut)
    else $error("disabled clock output toggled");
  a_ccr_write: assert property (s_clkctl_write |=> st.ccr == $past(pwdata[7:0]))
    else $error("clock control write not stored");
  a_sec_wrap: assert property (
    tick1s && st.tm[0] == 8'h59 && !wrEn |=> st.tm[0] == 8'h00)
    else $error("seconds did not wrap at 59");

endmodule
`default_nettype wire

// file: design/rtcp_pkg.sv
// rtcp_pkg: shared constants, register indices, field positions and state types
// for the real-time clock core; assumes a 125 MHz system clock.
`default_nettype none
package rtcp_pkg;
  // clock and time base
  localparam int CLK_HZ = 125_000_000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SUB_RATE_HZ = 128;                      // watchdog / sub-second rate
  localparam int SUB_CYCLES_DEF = CLK_HZ / SUB_RATE_HZ;   // rounds down
  localparam int SENSE_DELAY_NS = 2_680_000;               // least quiet time on line
  localparam int SENSE_CYCLES_DEF = (SENSE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] LINE_50 = 6'h32;                  // 50 rising edges a second
  localparam logic [5:0] LINE_60 = 6'h3C;                  // 60 rising edges a second
  localparam logic [1:0] WD_LAST = 2'h2;                   // third silent tick fires
  localparam logic [2:0] START_WAIT = 3'h5;                // sense input settled
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_RAM_LAST = 6'h1F;
  localparam logic [5:0] IDX_SEC = 6'h20;
  localparam logic [5:0] IDX_YEAR = 6'h26;
  localparam logic [5:0] IDX_ALM_SEC = 6'h28;
  localparam logic [5:0] IDX_ALM_HR = 6'h2A;
  localparam logic [5:0] IDX_STATUS = 6'h30;
  localparam logic [5:0] IDX_CLKCTL = 6'h31;
  localparam logic [5:0] IDX_INTCTL = 6'h32;
  // clock control fields
  localparam int CCR_START = 7;
  localparam int CCR_LINE = 6;
  localparam int CCR_50HZ = 3;
  localparam logic [2:0] CKO_OFF = 3'h4;
  localparam logic [2:0] CKO_1HZ = 3'h5;
  localparam logic [2:0] CKO_2HZ = 3'h6;
  localparam logic [2:0] CKO_LINE = 3'h7;
  // interrupt control fields
  localparam int ICR_WDOG = 7;
  localparam int ICR_PDOWN = 6;
  localparam int ICR_PSENSE = 5;
  localparam int ICR_ALARM = 4;
  // status fields
  localparam int ST_ALARM = 0;
  localparam int ST_PERIOD = 1;
  localparam int ST_PSENSE = 2;
  localparam int ST_WDOG = 6;
  // hours fields
  localparam int HR_12 = 7;
  localparam int HR_PM = 5;
  // reset values
  localparam logic [7:0] CCR_RST = 8'h00;
  localparam logic [7:0] ICR_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h10;               // first-time-up set
  localparam logic [7:0] CAL_RST = 8'h01;                  // day, date, month

  typedef enum logic [1:0] {
    MODE_START = 2'b00,
    MODE_SINGLE = 2'b01,
    MODE_BATTERY = 2'b10
  } rtcp_mode_type;

  typedef struct packed {
    logic [2:0] s1, s2, s3, filt;                          // 0 ce, 1 line, 2 sys
    rtcp_mode_type mode;
    logic [2:0] startCnt;
    logic sawLow;
    logic [7:0] ccr, icr, status, rdata;
    logic [6:0][7:0] tm;
    logic [2:0][7:0] alm;
    logic [31:0][7:0] ram;
    logic [19:0] subCnt, senseCnt;
    logic [6:0] hz128;
    logic [5:0] lineCnt;
    logic [3:0] fast;
    logic cmpPend, senseDone, ceSeen, wdPulse, wdLock, intLow;
    logic [1:0] wdCnt;
    logic supply_enable_out, cpuRstN, clkOut;
  } rtcp_state_type;
endpackage
`default_nettype wire

// file: verif/rtcp_host_model.sv
// rtcp_host_model: far-side host pins; open-drain wires and chip-enable service.
// assumes the core drives open-drain enables high while pulling a wire low.
`default_nettype none
module rtcp_host_model (
  // clock
  input wire logic clk,
  // service control from the bench
  input wire logic serviceOn,
  output logic chipEnable,
  // open-drain enables from the core
  input wire logic cpuResetOe,
  input wire logic intOe,
  // resolved wire levels
  output logic cpuResetWire,
  output logic intWire
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] div = 2'h0;
  logic ceLevel = 1'b0;
  // pull-ups win unless the core pulls low
  assign cpuResetWire = cpuResetOe ? 1'b0 : 1'b1;
  assign intWire = intOe ? 1'b0 : 1'b1;
  // ce pin has a single driving process
  assign chipEnable = ceLevel;
  // regular ce toggle
  // toggles every fourth clock, well inside one watchdog tick
  always @(posedge clk)
  begin
    div <= div + 2'h1;
    if (serviceOn && div == 2'h3)
      ceLevel <= ~ceLevel;
  end
endmodule
`default_nettype wire

// file: verif/test_rtcp_core.sv
// test_rtcp_core: apb-driven sequences against the clock core with a host model.
// assumes shortened time base: 8 clocks per 128 Hz step, sense delay of 20 clocks.
`default_nettype none
module test_rtcp_core
  import rtcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, serviceOn, chipEnable;
  logic systemLevelIn, supplyEnableOut, clkOut, cpuResetOutN, cpuResetOe;
  logic intOutN, intOe, cpuResetWire, intWire, a, b, lineIn;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  rtcp_core #(.SUB_CYCLES(8), .SENSE_CYCLES(20)) dut (.clk(clk), .rst(rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .chipEnable(chipEnable),
    .lineIn(lineIn), .systemLevelIn(systemLevelIn), .supplyEnableOut(supplyEnableOut),
    .clkOut(clkOut), .cpuResetIn(cpuResetWire), .cpuResetOutN(cpuResetOutN),
    .cpuResetOe(cpuResetOe), .intIn(intWire), .intOutN(intOutN), .intOe(intOe));
  rtcp_host_model host (.clk(clk), .serviceOn(serviceOn), .chipEnable(chipEnable),
    .cpuResetOe(cpuResetOe), .intOe(intOe), .cpuResetWire(cpuResetWire), .intWire(intWire));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard: the whole sequence needs well under 10k clocks
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_pin(input logic got, input logic exp);
    check_data({31'h0, got}, {31'h0, exp});
  endtask
  // one apb transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0000_00, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // only the bench timeout ends a wait
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp, input logic experr);
    apb(1'b0, idx, 8'h00);
    check_data(rd, {24'h0000_00, exp});
    check_pin(err, experr);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    serviceOn = 1'b0;
    systemLevelIn = 1'b1;
    lineIn = 1'b1;
    wt(3);
    rst <= 1'b0;
    wt(12);
    check_pin(supplyEnableOut, 1'b1);
    check_pin(cpuResetWire, 1'b1);
    rd_chk(IDX_STATUS, STATUS_RST, 1'b0);
    rd_chk(IDX_STATUS, 8'h00, 1'b0);
    rd_chk(6'h23, CAL_RST, 1'b0);
    rd_chk(IDX_CLKCTL, CCR_RST, 1'b0);
    // ram ends, counter, read-only status, unmapped index
    apb(1'b1, 6'h00, 8'hA5);
    apb(1'b1, IDX_RAM_LAST, 8'h3C);
    apb(1'b1, IDX_YEAR, 8'h99);
    apb(1'b1, IDX_STATUS, 8'hFF);
    rd_chk(6'h00, 8'hA5, 1'b0);
    rd_chk(IDX_RAM_LAST, 8'h3C, 1'b0);
    rd_chk(IDX_YEAR, 8'h99, 1'b0);
    rd_chk(IDX_STATUS, 8'h00, 1'b0);
    rd_chk(6'h27, 8'h00, 1'b1);
    // single-supply: sense low pulls cpu reset
    systemLevelIn <= 1'b0;
    wt(8);
    check_pin(cpuResetOutN, 1'b0);
    systemLevelIn <= 1'b1;
    wt(8);
    check_pin(cpuResetOutN, 1'b1);
    // clk/2 output toggles every clock, code 4 holds it low
    apb(1'b1, IDX_CLKCTL, 8'h00);
    wt(8);
    a = clkOut;
    wt(1);
    b = clkOut;
    check_pin(a ^ b, 1'b1);
    apb(1'b1, IDX_CLKCTL, {5'h00, CKO_OFF});
    wt(8);
    check_pin(clkOut, 1'b0);
    // time loaded while alarm interrupt is off
    apb(1'b1, IDX_SEC, 8'h00);
    apb(1'b1, IDX_ALM_SEC, 8'h01);
    apb(1'b1, 6'h29, 8'h00);
    apb(1'b1, IDX_ALM_HR, 8'h00);
    apb(1'b1, IDX_INTCTL, 8'h10);
    apb(1'b1, IDX_CLKCTL, 8'h84);
    wt(1536);
    rd_chk(IDX_SEC, 8'h01, 1'b0);
    check_pin(intWire, 1'b0);
    check_pin(intOutN, 1'b0);
    rd_chk(IDX_STATUS, 8'h01, 1'b0);
    wt(4);
    check_pin(intWire, 1'b1);
    // watchdog serviced, then starved
    serviceOn <= 1'b1;
    apb(1'b1, IDX_INTCTL, 8'h80);
    wt(200);
    check_pin(cpuResetOutN, 1'b1);
    serviceOn <= 1'b0;
    for (int i = 0; i < 200 && cpuResetOutN !== 1'b0; i++)
      wt(1);
    check_pin(cpuResetWire, 1'b0);
    apb(1'b1, IDX_INTCTL, 8'h00);
    apb(1'b0, IDX_STATUS, 8'h00);
    check_data(rd & 32'h0000_0040, 32'h0000_0040);
    wt(40);
    check_pin(cpuResetOutN, 1'b1);
    // power-down, then sense low-high wakes it
    apb(1'b1, IDX_CLKCTL, 8'h85);
    apb(1'b1, IDX_INTCTL, 8'h40);
    wt(8);
    check_pin(supplyEnableOut, 1'b0);
    check_pin(clkOut, 1'b0);
    check_pin(cpuResetOutN, 1'b0);
    apb(1'b0, IDX_SEC, 8'h00);
    check_pin(err, 1'b1);
    systemLevelIn <= 1'b0;
    wt(10);
    systemLevelIn <= 1'b1;
    wt(10);
    check_pin(supplyEnableOut, 1'b1);
    check_pin(cpuResetOutN, 1'b1);
    // line activity holds power sense off; a quiet line then wakes power-down
    apb(1'b1, IDX_INTCTL, 8'h60);
    repeat (10)
    begin
      lineIn <= ~lineIn;
      wt(4);
    end
    check_pin(supplyEnableOut, 1'b0);
    wt(40);
    check_pin(supplyEnableOut, 1'b1);
    check_pin(intWire, 1'b0);
    rd_chk(IDX_STATUS, 8'h04, 1'b0);
    wt(4);
    check_pin(intWire, 1'b1);
    // alarm interrupt off and clock stopped while the time is loaded
    apb(1'b1, IDX_INTCTL, 8'h00);
    apb(1'b1, IDX_CLKCTL, 8'h05);
    apb(1'b1, IDX_SEC, 8'h59);
    apb(1'b1, 6'h21, 8'h59);
    apb(1'b1, 6'h22, 8'h91);
    apb(1'b1, IDX_ALM_SEC, 8'h00);
    apb(1'b1, 6'h29, 8'h00);
    apb(1'b1, IDX_ALM_HR, 8'h32);
    apb(1'b1, IDX_CLKCTL, 8'h84);
    wt(1100);
    rd_chk(6'h22, 8'hB2, 1'b0);
    rd_chk(IDX_SEC, 8'h00, 1'b0);
    check_pin(intWire, 1'b1);
    rd_chk(IDX_STATUS, 8'h01, 1'b0);
    // battery-backup: second reset with the sense input low
    systemLevelIn <= 1'b0;
    rst <= 1'b1;
    wt(3);
    rst <= 1'b0;
    wt(12);
    check_pin(supplyEnableOut, 1'b0);
    check_pin(cpuResetWire, 1'b0);
    check_pin(clkOut, 1'b0);
    systemLevelIn <= 1'b1;
    wt(8);
    check_pin(supplyEnableOut, 1'b1);
    check_pin(cpuResetOutN, 1'b1);
    systemLevelIn <= 1'b0;
    wt(8);
    check_pin(supplyEnableOut, 1'b0);
    check_pin(cpuResetOutN, 1'b0);
    check_pin(clkOut, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
